// ==== design/timer_pw_measure.sv ====
/*
  two timer/event counters (8-bit and 16-bit) with pulse width measurement,
  apb register access, overflow flags, interrupt vector and wake-up.
  assumes pins arrive asynchronously; power_down and int_ack come from the
  core on pclk; port direction lives outside, the pull-high option is a register driven out on pull_high_en.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_pw_measure (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pw_pkg::addr_w-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer0_input_pin,
  input wire logic timer1_input_pin,
  input wire logic power_down,
  input wire logic int_ack,
  output logic int_req,
  output logic [7:0] int_vector,
  output logic wakeup,
  output logic [1:0] pull_high_en
);
  import timer_pw_pkg::*;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [1:0] prescale;
    logic [1:0][1:0] mode;
    logic [1:0] run;
    logic [1:0] edge_sel;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] pre;
    pw_state_e [1:0] pw_st;
    logic [1:0] pend;
    logic [7:0] low_buf;
    logic [7:0] rd_latch;
    logic emi;
    logic [1:0] ie;
    logic [1:0] flag;
    logic [1:0] pull;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic wakeup;
    logic int_req;
    logic [7:0] int_vector;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic tick;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] start_edge;
  logic [1:0] stop_edge;
  logic [1:0] ev_edge;
  logic [1:0] inhibit;
  logic [1:0] inc;
  logic [1:0] ovf;
  logic [1:0][15:0] full;

  assign tick = (state_reg.prescale == prescale_last);
  assign setup = psel & ~penable;
  assign access = psel & penable & state_reg.pready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign inhibit[0] = access & (paddr == addr_t0_count);
  assign inhibit[1] = access & ((paddr == addr_t1_low) | (paddr == addr_t1_high));
  assign full[0] = full_t0;
  assign full[1] = full_t1;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign rise[gi] = state_reg.sync2[gi] & ~state_reg.prev[gi];
      assign fall[gi] = ~state_reg.sync2[gi] & state_reg.prev[gi];
      assign start_edge[gi] = state_reg.edge_sel[gi] ? rise[gi] : fall[gi];
      assign stop_edge[gi] = state_reg.edge_sel[gi] ? fall[gi] : rise[gi];
      assign ev_edge[gi] = state_reg.edge_sel[gi] ? fall[gi] : rise[gi];
      assign inc[gi] = state_reg.run[gi] & ~inhibit[gi] &
        (((state_reg.mode[gi] == mode_timer) & tick) |
         ((state_reg.mode[gi] == mode_event) & ev_edge[gi]) |
         ((state_reg.mode[gi] == mode_pulse) & (state_reg.pw_st[gi] == pw_count) &
          tick & ~state_reg.pend[gi]));
      assign ovf[gi] = inc[gi] & (state_reg.cnt[gi] == full[gi]);
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.sync1 = {timer1_input_pin, timer0_input_pin};
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    state_next.prescale = tick ? 2'h0 : state_reg.prescale + 2'h1;
    state_next.pready = setup;
    state_next.pslverr = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (ovf[i]) begin
        state_next.cnt[i] = state_reg.pre[i];
      end else if (inc[i]) begin
        state_next.cnt[i] = (state_reg.cnt[i] + 16'h0001) & full[i];
      end
      unique case (state_reg.pw_st[i])
        pw_idle: begin
          state_next.pend[i] = 1'b0;
          if (state_reg.run[i] && state_reg.mode[i] == mode_pulse) begin
            state_next.pw_st[i] = pw_armed;
          end
        end
        pw_armed: begin
          if (!state_reg.run[i] || state_reg.mode[i] != mode_pulse) begin
            state_next.pw_st[i] = pw_idle;
          end else if (state_reg.pend[i] && tick) begin
            state_next.pw_st[i] = pw_count;
            state_next.pend[i] = 1'b0;
          end else if (start_edge[i]) begin
            state_next.pend[i] = 1'b1;
          end
        end
        pw_count: begin
          if (!state_reg.run[i] || state_reg.mode[i] != mode_pulse) begin
            state_next.pw_st[i] = pw_idle;
          end else if (state_reg.pend[i] && tick) begin
            state_next.pw_st[i] = pw_idle;
            state_next.run[i] = 1'b0;
            state_next.pend[i] = 1'b0;
          end else if (stop_edge[i]) begin
            state_next.pend[i] = 1'b1;
          end
        end
        default: begin
          state_next.pw_st[i] = pw_idle;
        end
      endcase
    end
    // servicing clears flag and master enable
    if (int_ack) begin
      state_next.emi = 1'b0;
      if (state_reg.flag[0] && state_reg.ie[0]) begin
        state_next.flag[0] = 1'b0;
      end else begin
        state_next.flag[1] = 1'b0;
      end
    end
    if (wr) begin
      unique case (paddr)
        addr_t0_ctrl: begin
          // mode field, run and edge select; run is also cleared by hardware at the end of a pulse measurement
          state_next.mode[0] = pwdata[mode_lo_bit+1:mode_lo_bit];
          state_next.run[0] = pwdata[run_bit];
          state_next.edge_sel[0] = pwdata[edge_bit];
        end
        addr_t1_ctrl: begin
          state_next.mode[1] = pwdata[mode_lo_bit+1:mode_lo_bit];
          state_next.run[1] = pwdata[run_bit];
          state_next.edge_sel[1] = pwdata[edge_bit];
        end
        addr_t0_count: begin
          state_next.pre[0] = {8'h00, pwdata[7:0]};
          if (!state_reg.run[0]) begin
            state_next.cnt[0] = {8'h00, pwdata[7:0]};
          end
        end
        addr_t1_low: begin
          state_next.low_buf = pwdata[7:0];
        end
        addr_t1_high: begin
          state_next.pre[1] = {pwdata[7:0], state_reg.low_buf};
          if (!state_reg.run[1]) begin
            state_next.cnt[1] = {pwdata[7:0], state_reg.low_buf};
          end
        end
        addr_intc: begin
          state_next.emi = pwdata[emi_bit];
          state_next.ie = {pwdata[ie1_bit], pwdata[ie0_bit]};
          state_next.flag = {pwdata[flag1_bit], pwdata[flag0_bit]};
        end
        addr_pull: begin
          state_next.pull = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    if (rd && paddr == addr_t1_high) begin
      state_next.rd_latch = state_reg.cnt[1][7:0];
    end
    state_next.flag = state_next.flag | ovf;
    // wake in power down when an overflow sets a flag that was clear
    state_next.wakeup = power_down & (|(ovf & ~state_reg.flag));
    state_next.int_req = state_next.emi & (|(state_next.flag & state_next.ie));
    state_next.int_vector = (state_next.flag[0] & state_next.ie[0]) ? vector_t0 : vector_t1;
    state_next.prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      unique case (paddr)
        addr_t0_ctrl: state_next.prdata[7:0] = {state_reg.mode[0], 1'b0, state_reg.run[0],
                                                 state_reg.edge_sel[0], 3'h0};
        addr_t1_ctrl: state_next.prdata[7:0] = {state_reg.mode[1], 1'b0, state_reg.run[1],
                                                 state_reg.edge_sel[1], 3'h0};
        addr_t0_count: state_next.prdata[7:0] = state_reg.cnt[0][7:0];
        addr_t1_low: state_next.prdata[7:0] = state_reg.rd_latch;
        addr_t1_high: state_next.prdata[7:0] = state_reg.cnt[1][15:8];
        addr_intc: state_next.prdata[7:0] = {1'b0, state_reg.flag, 1'b0, state_reg.ie,
                                              1'b0, state_reg.emi};
        addr_pull: state_next.prdata[1:0] = state_reg.pull;
        default: state_next.pslverr = 1'b1;
      endcase
    end else if (setup) begin
      unique case (paddr)
        addr_t0_ctrl, addr_t1_ctrl, addr_t0_count, addr_t1_low, addr_t1_high,
        addr_intc, addr_pull: state_next.pslverr = 1'b0;
        default: state_next.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign int_req = state_reg.int_req;
  assign int_vector = state_reg.int_vector;
  assign wakeup = state_reg.wakeup;
  assign pull_high_en = state_reg.pull;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence tick_seq;
    tick ##1 !tick [*3] ##1 tick;
  endsequence
  sequence pw_stop_seq;
    state_reg.pw_st[0] == pw_count && state_reg.pend[0] && tick && state_reg.run[0] &&
      state_reg.mode[0] == mode_pulse && !wr;
  endsequence

  a_prescale_period: assert property (tick |-> tick_seq)
    else $error("timer clock not every fourth cycle");
  a_pw_run_clear: assert property (pw_stop_seq |=> !state_reg.run[0] &&
      state_reg.pw_st[0] == pw_idle)
    else $error("run bit not cleared at pulse end");
  a_run_kept: assert property (state_reg.run[0] && state_reg.mode[0] != mode_pulse && !wr
      |=> state_reg.run[0])
    else $error("run bit cleared by hardware");
  a_armed_hold: assert property (state_reg.pw_st[0] == pw_armed && !wr
      |=> $stable(state_reg.cnt[0]))
    else $error("counter moved before active edge");
  a_ovf_reload: assert property (ovf[0] && !wr |=> state_reg.cnt[0] == $past(state_reg.pre[0])
      && state_reg.flag[0])
    else $error("overflow did not reload and flag");
  a_int_masked: assert property (!state_next.ie[0] && !state_next.ie[1]
      |=> !int_req)
    else $error("request without enable");
  a_vector_t0: assert property (int_req && int_vector == vector_t0
      |-> state_reg.flag[0] && state_reg.ie[0])
    else $error("timer zero vector without cause");
  a_read_inhibit: assert property (inhibit[0] && !pwrite |=> $stable(state_reg.cnt[0]))
    else $error("counter moved during read");
  a_wake_new: assert property (ovf[1] && power_down && !state_reg.flag[1]
      |=> wakeup ##1 !wakeup)
    else $error("no wake pulse on overflow");
  a_idle_hold: assert property (state_reg.mode[0] == mode_pulse && !state_reg.run[0] && !wr
      |=> $stable(state_reg.cnt[0]))
    else $error("counter moved after measurement");
endmodule

`default_nettype wire

// ==== design/timer_pw_pkg.sv ====
/*
  constants and types for the pulse width timer block: register offsets,
  control and interrupt bit positions, mode codes, full counts, vectors.
  assumes a 32-bit apb slave with byte addresses and one word per register.
*/
package timer_pw_pkg;
  localparam int addr_w = 8;
  localparam logic [7:0] addr_t0_ctrl = 8'h00;
  localparam logic [7:0] addr_t0_count = 8'h04;
  localparam logic [7:0] addr_t1_ctrl = 8'h08;
  localparam logic [7:0] addr_t1_low = 8'h0c;
  localparam logic [7:0] addr_t1_high = 8'h10;
  localparam logic [7:0] addr_intc = 8'h14;
  localparam logic [7:0] addr_pull = 8'h18;
  localparam int mode_lo_bit = 6;
  localparam int run_bit = 4;
  localparam int edge_bit = 3;
  localparam int emi_bit = 0;
  localparam int ie0_bit = 2;
  localparam int ie1_bit = 3;
  localparam int flag0_bit = 5;
  localparam int flag1_bit = 6;
  localparam logic [1:0] mode_event = 2'h1;
  localparam logic [1:0] mode_timer = 2'h2;
  localparam logic [1:0] mode_pulse = 2'h3;
  localparam logic [1:0] mode_rst = 2'h0;
  localparam logic [15:0] full_t0 = 16'h00ff;
  localparam logic [15:0] full_t1 = 16'hffff;
  localparam logic [15:0] count_rst = 16'h0000;
  localparam logic [7:0] vector_t0 = 8'h08;
  localparam logic [7:0] vector_t1 = 8'h0c;
  localparam int prescale_div = 4;
  localparam logic [1:0] prescale_last = 2'(prescale_div - 1);
  typedef enum logic [1:0] {pw_idle, pw_armed, pw_count} pw_state_e;
endpackage

// ==== test/pin_source.sv ====
/*
  pulse source for one timer input pin.
  assumes go is a one-cycle strobe on pclk; idle_lvl is the resting level.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic pclk,
  input wire logic go,
  input wire logic idle_lvl,
  input wire logic [15:0] width,
  output logic pin
);
  logic [15:0] left_reg;
  initial left_reg = 16'h0;
  // drives the pin only as a timer input
  always @(posedge pclk) begin
    if (go)
      left_reg <= width;
    else if (left_reg != 16'h0)
      left_reg <= left_reg - 16'h1;
  end
  // pulse levels held for whole clocks, asynchronous to the ticks
  assign pin = (left_reg != 16'h0) ? ~idle_lvl : idle_lvl;
endmodule
`default_nettype wire

// ==== test/tb_timer_pw_measure.sv ====
/*
  testbench for the pulse width timer: apb tasks, pin sources, random widths.
  assumes the design package and the pin_source model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pw_measure;
  import timer_pw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, power_down, int_ack;
  logic pready, pslverr, int_req, wakeup, er;
  logic [7:0] paddr, int_vector;
  logic [31:0] pwdata, prdata, v;
  logic [1:0] pull_high_en, go, idle;
  logic [15:0] wid;
  wire [1:0] pin;
  int mismatches, n_compared, wakes, w;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (wakeup === 1'b1) wakes <= wakes + 1;
  pin_source u_pin_source0 (.pclk(pclk), .go(go[0]), .idle_lvl(idle[0]), .width(wid),
    .pin(pin[0]));
  pin_source u_pin_source1 (.pclk(pclk), .go(go[1]), .idle_lvl(idle[1]), .width(wid),
    .pin(pin[1]));
  timer_pw_measure u_timer_pw_measure (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_input_pin(pin[0]),
    .timer1_input_pin(pin[1]), .power_down(power_down), .int_ack(int_ack),
    .int_req(int_req), .int_vector(int_vector), .wakeup(wakeup),
    .pull_high_en(pull_high_en));
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rdat, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d, er);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic r, input logic e);
    return {24'h0, m, 1'b0, r, e, 3'h0};
  endfunction
  function automatic logic [7:0] ca(input int t);
    return (t == 0) ? addr_t0_ctrl : addr_t1_ctrl;
  endfunction
  task automatic wrc(input int t, input logic [15:0] p);
    if (t == 0)
      wr(addr_t0_count, {24'h0, p[7:0]});
    else begin
      wr(addr_t1_low, {24'h0, p[7:0]});
      wr(addr_t1_high, {24'h0, p[15:8]});
    end
  endtask
  task automatic rdc(input int t, output logic [31:0] c);
    logic [31:0] h;
    if (t == 0)
      rd(addr_t0_count, c);
    else begin
      rd(addr_t1_high, h);
      rd(addr_t1_low, c);
      c = {16'h0, h[7:0], c[7:0]};
    end
  endtask
  task automatic pulse(input int t, input int n);
    wid <= 16'(n);
    go[t] <= 1'b1;
    @(posedge pclk);
    go[t] <= 1'b0;
    cyc(n + 24);
  endtask
  task automatic measure(input int t, input logic e);
    logic [31:0] c;
    w = $urandom_range(300, 40);
    idle[t] <= ~e;
    wrc(t, 16'h0);
    wr(ca(t), ctl(mode_pulse, 1'b0, e));
    wr(ca(t), ctl(mode_pulse, 1'b1, e));
    cyc(20);
    rdc(t, c);
    chk(c, 0, 0);
    pulse(t, w);
    rd(ca(t), c);
    chk(c, ctl(mode_pulse, 1'b0, e), ctl(mode_pulse, 1'b0, e));
    rdc(t, v);
    chk(v, 32'(w / 4 - 2), 32'(w / 4 + 2));
    pulse(t, w / 2);
    rdc(t, c);
    chk(c, v, v);
    $display("test measure %0d %0d done", t, e);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    report_and_stop();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    power_down = 0; int_ack = 0; go = 0; idle = 2'b11; wid = 0;
    wakes = 0; mismatches = 0; n_compared = 0;
    void'($urandom(32'h0974));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4), v);
      chk(v, 0, 0);
      chk(32'(er), 32'(a == 7), 32'(a == 7));
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) measure(i / 2, 1'(i % 2));
    idle[0] <= 1'b1;
    wrc(0, 16'h00f0);
    wr(addr_t0_ctrl, ctl(mode_pulse, 1'b0, 1'b0));
    wr(addr_t0_ctrl, ctl(mode_pulse, 1'b1, 1'b0));
    pulse(0, 200);
    rdc(0, v);
    chk(v, 32'hf0, 32'hff);
    rd(addr_intc, v);
    chk(v, 32'h20, 32'h20);
    chk(32'(int_req), 0, 0);
    wr(addr_intc, 32'h25);
    cyc(2);
    chk(32'(int_req), 1, 1);
    chk(32'(int_vector), 32'(vector_t0), 32'(vector_t0));
    int_ack <= 1'b1;
    @(posedge pclk);
    int_ack <= 1'b0;
    cyc(2);
    chk(32'(int_req), 0, 0);
    rd(addr_intc, v);
    chk(v, 32'h04, 32'h04);
    $display("test overflow done");
    wrc(0, 16'h0);
    wr(addr_t0_ctrl, ctl(mode_timer, 1'b0, 1'b0));
    wr(addr_t0_ctrl, ctl(mode_timer, 1'b1, 1'b0));
    cyc(400);
    rd(addr_t0_ctrl, v);
    chk(v, ctl(mode_timer, 1'b1, 1'b0), ctl(mode_timer, 1'b1, 1'b0));
    rdc(0, v);
    chk(v, 95, 110);
    wr(addr_t0_ctrl, 32'h0);
    $display("test timer done");
    wr(addr_intc, 32'h0);
    idle[1] <= 1'b0;
    power_down <= 1'b1;
    wrc(1, 16'hffff);
    wr(addr_t1_ctrl, ctl(mode_event, 1'b0, 1'b0));
    wr(addr_t1_ctrl, ctl(mode_event, 1'b1, 1'b0));
    pulse(1, 4);
    chk(32'(wakes), 1, 1);
    rd(addr_intc, v);
    chk(v, 32'h40, 32'h40);
    pulse(1, 4);
    chk(32'(wakes), 1, 1);
    power_down <= 1'b0;
    $display("test wake done");
    wrc(1, 16'h1230);
    rdc(1, v);
    chk(v, 32'hffff, 32'hffff);
    pulse(1, 4);
    rdc(1, v);
    chk(v, 32'h1230, 32'h1230);
    wr(addr_t1_ctrl, ctl(mode_event, 1'b0, 1'b1));
    wr(addr_t1_ctrl, ctl(mode_event, 1'b1, 1'b1));
    pulse(1, 4);
    rdc(1, v);
    chk(v, 32'h1231, 32'h1231);
    wr(addr_intc, 32'h49);
    cyc(2);
    chk(32'(int_req), 1, 1);
    chk(32'(int_vector), 32'(vector_t1), 32'(vector_t1));
    $display("test event done");
    w = $urandom_range(3, 0);
    wr(addr_pull, 32'(w));
    cyc(2);
    chk(32'(pull_high_en), 32'(w), 32'(w));
    $display("test pull done");
    report_and_stop();
  end
endmodule
`default_nettype wire
